// >>> rtl/psi_setpoint.sv
// Operation
// R1: the sixteen lines are read as four bcd digits up to 9999 or binary up to FFFFH.
// R2: with strobe gating the captured word follows the lines only while the strobe is on.
// R3: bcd digits sit on lines 0-3, 4-7, 8-11, 12-15 as units to thousands, low line first.
// R4: binary reading takes line 0 as lsb and line 15 as msb of an unsigned word.
// R5: a bcd digit above 9 rejects the word and the previous value stays in use.
// R6: input type resets to 9999, which disables the command; 0 to 3 enable it.
// R7: strobe use takes only 0 or 1 and resets to 0.
// R8: both biases span 0 to 3600 r/min in 0.1 steps, reset to 0, output at zero input.
// R9: both gains span 0 to 3600 r/min in 1 steps or 9999, reset to 1500.
// R10: increment select takes 0 to 2, resets to 1, never written while running.
// R11: the word is a hexadecimal quantity in binary and a decimal one in bcd.
// R12: type 0 is bcd, 1 binary, 2 bcd with compensation, 3 binary with it.
// R13: strobe use 0 samples the lines always, 1 only while the strobe is on.
// R14: strobe use 1 with the strobe off from power-up reads all lines as off.
// R15: gain 9999 gives the input times 0.1 r/min for select 0, else 1 r/min.
// R16: other gains interpolate from bias at zero to gain at full-scale input.
`timescale 1ns/1ns
`default_nettype none

module psi_setpoint import psi_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // setpoint lines from the outside controller
  input wire logic [15:0] SETPOINT_LINES,
  input wire logic DATA_READ_STROBE,
  // drive state
  input wire logic DRIVE_RUNNING,
  input wire logic [1:0] PARAMETER_WRITE_PROTECT,
  // settings port
  input wire logic SET_WR,
  input wire logic [2:0] SET_ID,
  input wire logic [15:0] SET_DATA,
  output logic SET_ACK,
  output logic SET_REFUSED,
  output logic [15:0] SET_RDATA,
  // speed command out, 0.1 r/min units
  output logic [19:0] SPEED_CMD,
  output logic SPEED_CMD_VALID,
  output logic SPEED_CMD_ENABLE,
  output logic ANALOG_COMP_ENABLE,
  output logic BCD_DIGIT_ERROR
);

  ////////////////////////////////////////////////////////////////////
  // settings

  logic [15:0] type_r, type_nxt;
  logic [15:0] strobe_r, strobe_nxt;
  logic [15:0] bcd_bias_r, bcd_bias_nxt;
  logic [15:0] bcd_gain_r, bcd_gain_nxt;
  logic [15:0] bin_bias_r, bin_bias_nxt;
  logic [15:0] bin_gain_r, bin_gain_nxt;
  logic [15:0] inc_r, inc_nxt;
  logic ack_r, ack_nxt;
  logic ref_r, ref_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic legal;
  logic locked;

  // range check of a write, by setting
  always_comb begin
    legal = 1'b0;
    if (SET_ID == SID_BCD_BIAS || SET_ID == SID_BIN_BIAS) begin
      legal = SET_DATA <= BIAS_MAX; // R8
    end else if (SET_ID == SID_BCD_GAIN || SET_ID == SID_BIN_GAIN) begin
      legal = (SET_DATA <= GAIN_MAX) || (SET_DATA == GAIN_DIRECT); // R9
    end else if (SET_ID == SID_TYPE) begin
      legal = (SET_DATA <= TYPE_BIN_COMP) || (SET_DATA == TYPE_OFF); // R6
    end else if (SET_ID == SID_STROBE) begin
      legal = SET_DATA <= STROBE_MAX; // R7
    end else if (SET_ID == SID_INC) begin
      legal = SET_DATA <= INC_MAX; // R10
    end
  end

  // run-time writes need the permissive protect code; the increment
  // select stays locked in run whatever the protect code says
  always_comb begin
    locked = DRIVE_RUNNING && ((PARAMETER_WRITE_PROTECT != WP_RUN_OK)
      || (SET_ID == SID_INC)); // R10
  end

  // apply a legal, unlocked write; answer with ack or refuse
  always_comb begin
    type_nxt = type_r;
    strobe_nxt = strobe_r;
    bcd_bias_nxt = bcd_bias_r;
    bcd_gain_nxt = bcd_gain_r;
    bin_bias_nxt = bin_bias_r;
    bin_gain_nxt = bin_gain_r;
    inc_nxt = inc_r;
    ack_nxt = 1'b0;
    ref_nxt = 1'b0;
    if (SET_WR && (!legal || locked)) begin
      ref_nxt = 1'b1;
    end else if (SET_WR) begin
      ack_nxt = 1'b1;
      case (SET_ID)
        SID_BCD_BIAS: bcd_bias_nxt = SET_DATA;
        SID_BCD_GAIN: bcd_gain_nxt = SET_DATA;
        SID_BIN_BIAS: bin_bias_nxt = SET_DATA;
        SID_BIN_GAIN: bin_gain_nxt = SET_DATA;
        SID_TYPE: type_nxt = SET_DATA;
        SID_STROBE: strobe_nxt = SET_DATA;
        SID_INC: inc_nxt = SET_DATA;
        default: ack_nxt = 1'b1;
      endcase
    end
  end

  // read back of the selected setting, one cycle behind SET_ID
  always_comb begin
    case (SET_ID)
      SID_BCD_BIAS: rdata_nxt = bcd_bias_r;
      SID_BCD_GAIN: rdata_nxt = bcd_gain_r;
      SID_BIN_BIAS: rdata_nxt = bin_bias_r;
      SID_BIN_GAIN: rdata_nxt = bin_gain_r;
      SID_TYPE: rdata_nxt = type_r;
      SID_STROBE: rdata_nxt = strobe_r;
      SID_INC: rdata_nxt = inc_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // settings come out of reset at their factory values
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      type_r <= RST_TYPE; // R6
      strobe_r <= RST_STROBE; // R7
      bcd_bias_r <= RST_BIAS; // R8
      bin_bias_r <= RST_BIAS; // R8
      bcd_gain_r <= RST_GAIN; // R9
      bin_gain_r <= RST_GAIN; // R9
      inc_r <= RST_INC; // R10
      ack_r <= 1'b0;
      ref_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      type_r <= type_nxt;
      strobe_r <= strobe_nxt;
      bcd_bias_r <= bcd_bias_nxt;
      bin_bias_r <= bin_bias_nxt;
      bcd_gain_r <= bcd_gain_nxt;
      bin_gain_r <= bin_gain_nxt;
      inc_r <= inc_nxt;
      ack_r <= ack_nxt;
      ref_r <= ref_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // capture and decode

  logic enabled;
  logic is_bin;
  logic sample;
  logic [15:0] word_r, word_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic err_r, err_nxt;
  logic [15:0] dec_val;
  logic dec_ok;

  // mode decode of the type setting
  always_comb begin
    enabled = type_r != TYPE_OFF; // R6
    is_bin = type_is_bin(type_r); // R12
  end

  // strobe gate; word resets to all off so a dark strobe reads zero
  always_comb begin
    sample = (strobe_r == 16'h0000) || DATA_READ_STROBE; // R13
    word_nxt = sample ? SETPOINT_LINES : word_r; // R2 R1
  end

  psi_word_decode u_decode (
    .word(word_r),
    .is_bin(is_bin),
    .value(dec_val),
    .valid(dec_ok)
  );

  // an illegal bcd word never reaches the accepted value
  always_comb begin
    acc_nxt = dec_ok ? dec_val : acc_r; // R5
    err_nxt = !dec_ok;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      word_r <= 16'h0000; // R14
      acc_r <= 16'h0000;
      err_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      acc_r <= acc_nxt;
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // speed computation

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_CALC = 2'b01
  } psi_ms_e;

  psi_ms_e st_r, st_nxt;
  logic [19:0] speed_r, speed_nxt;
  logic valid_r, valid_nxt;
  logic [15:0] sel_gain;
  logic start;

  psi_calc_if cif();

  psi_scaler u_scaler (
    .clk(CLK),
    .rst_n(RESET_N),
    .cif(cif)
  );

  // pick the gain by input reading; bias and full scale are picked below
  always_comb begin
    sel_gain = is_bin ? bin_gain_r : bcd_gain_r;
  end

  // request fields; the scaler latches them on start
  always_comb begin
    cif.start = start;
    cif.x = acc_r;
    cif.bias = is_bin ? bin_bias_r : bcd_bias_r; // R8
    cif.gain = sel_gain; // R9
    cif.full = is_bin ? BIN_FULL : BCD_FULL; // R16
    cif.direct = sel_gain == GAIN_DIRECT; // R15
    cif.fine = inc_r == INC_FINE; // R15
  end

  // recompute continuously; the output holds the last result between
  // passes, so a setting change shows after two passes at most
  always_comb begin
    st_nxt = st_r;
    speed_nxt = speed_r;
    valid_nxt = valid_r;
    start = 1'b0;
    case (st_r)
      MS_IDLE: begin
        if (enabled) begin
          start = 1'b1;
          st_nxt = MS_CALC;
        end else begin
          speed_nxt = 20'h00000;
          valid_nxt = 1'b0;
        end
      end
      MS_CALC: begin
        // disable clears the command at once, not only at pass end
        if (!enabled) begin
          speed_nxt = 20'h00000;
          valid_nxt = 1'b0;
        end
        if (cif.done) begin
          st_nxt = MS_IDLE;
          // a result finished after disable is dropped
          speed_nxt = enabled ? cif.result : 20'h00000;
          valid_nxt = enabled;
        end
      end
      default: st_nxt = MS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= MS_IDLE;
      speed_r <= 20'h00000;
      valid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      speed_r <= speed_nxt;
      valid_r <= valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // compensation summing itself lives outside this block
  always_comb begin
    SPEED_CMD = speed_r;
    SPEED_CMD_VALID = valid_r;
    SPEED_CMD_ENABLE = enabled; // R6
    ANALOG_COMP_ENABLE = (type_r == TYPE_BCD_COMP) // R12
      || (type_r == TYPE_BIN_COMP);
    BCD_DIGIT_ERROR = err_r;
    SET_ACK = ack_r;
    SET_REFUSED = ref_r;
    SET_RDATA = rdata_r;
  end

endmodule

`default_nettype wire

// >>> rtl/psi_pkg.sv
package psi_pkg;

  // word and result widths
  localparam int PSI_WORD_W = 16;
  localparam int PSI_OUT_W = 20;

  // input type selection codes
  localparam logic [15:0] TYPE_BCD = 16'h0000;
  localparam logic [15:0] TYPE_BIN = 16'h0001;
  localparam logic [15:0] TYPE_BCD_COMP = 16'h0002;
  localparam logic [15:0] TYPE_BIN_COMP = 16'h0003;
  localparam logic [15:0] TYPE_OFF = 16'h270F; // 9999

  // setting ranges and special values
  localparam logic [15:0] BCD_FULL = 16'h270F; // 9999
  localparam logic [15:0] BIN_FULL = 16'hFFFF;
  localparam logic [15:0] GAIN_DIRECT = 16'h270F; // 9999
  localparam logic [15:0] BIAS_MAX = 16'h8CA0; // 3600.0 r/min
  localparam logic [15:0] GAIN_MAX = 16'h0E10; // 3600 r/min
  localparam logic [15:0] STROBE_MAX = 16'h0001;
  localparam logic [15:0] INC_MAX = 16'h0002;
  localparam logic [15:0] INC_FINE = 16'h0000; // 0.1 r/min steps
  localparam logic [1:0] WP_RUN_OK = 2'h2; // writes allowed in run
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [PSI_OUT_W-1:0] SPEED_PER_RPM = 20'h0000A;

  // reset values
  localparam logic [15:0] RST_TYPE = TYPE_OFF;
  localparam logic [15:0] RST_STROBE = 16'h0000;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h05DC; // 1500 r/min
  localparam logic [15:0] RST_INC = 16'h0001;

  // setting selector on the write port
  typedef enum logic [2:0] {
    SID_BCD_BIAS = 3'b000,
    SID_BCD_GAIN = 3'b001,
    SID_BIN_BIAS = 3'b010,
    SID_BIN_GAIN = 3'b011,
    SID_TYPE = 3'b100,
    SID_STROBE = 3'b101,
    SID_INC = 3'b110
  } psi_sid_e;

  // one bcd digit holds 0 to 9
  function automatic logic digit_ok(input logic [3:0] d);
    return d <= DIGIT_MAX;
  endfunction

  // binary reading for types 1 and 3
  function automatic logic type_is_bin(input logic [15:0] t);
    return (t == TYPE_BIN) || (t == TYPE_BIN_COMP);
  endfunction

endpackage

// >>> rtl/psi_calc_if.sv
`timescale 1ns/1ns
`default_nettype none

// request from the control logic to the scaler and its answer
interface psi_calc_if;
  logic start;
  logic direct;
  logic fine;
  logic [15:0] x;
  logic [15:0] bias;
  logic [15:0] gain;
  logic [15:0] full;
  logic done;
  logic [19:0] result;

  modport ctrl(output start, direct, fine, x, bias, gain, full,
    input done, result);
  modport scaler(input start, direct, fine, x, bias, gain, full,
    output done, result);
endinterface

`default_nettype wire

// >>> rtl/psi_word_decode.sv
`timescale 1ns/1ns
`default_nettype none

module psi_word_decode import psi_pkg::*; (
  // captured word and its reading
  input wire logic [15:0] word,
  input wire logic is_bin,
  // decoded value
  output logic [15:0] value,
  output logic valid
);

  logic [15:0] bcd_val;

  // weight the four digits, units on the low lines
  always_comb begin
    bcd_val = 16'(word[3:0]) // R3
      + 16'(word[7:4]) * 16'h000A
      + 16'(word[11:8]) * 16'h0064
      + 16'(word[15:12]) * 16'h03E8;
  end

  // binary is taken as is; bcd only when every digit is legal
  always_comb begin
    if (is_bin) begin
      value = word; // R4 R11
      valid = 1'b1;
    end else begin
      value = bcd_val; // R11
      valid = digit_ok(word[3:0]) && digit_ok(word[7:4]) // R5
        && digit_ok(word[11:8]) && digit_ok(word[15:12]);
    end
  end

endmodule

`default_nettype wire

// >>> rtl/psi_scaler.sv
`timescale 1ns/1ns
`default_nettype none

module psi_scaler import psi_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and answer
  psi_calc_if.scaler cif
);

  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_DIV = 2'b01,
    SC_END = 2'b10
  } psi_sc_e;

  psi_sc_e st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [16:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic neg_r, neg_nxt;
  logic [15:0] bias_r, bias_nxt;
  logic [15:0] full_r, full_nxt;
  logic [19:0] res_r, res_nxt;
  logic done_r, done_nxt;
  logic [15:0] span, mag;
  logic [16:0] rem_sh;

  // restoring divide, one quotient bit a cycle; small area over speed
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    neg_nxt = neg_r;
    bias_nxt = bias_r;
    full_nxt = full_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    span = 16'(cif.gain * 16'h000A);
    mag = (cif.bias > span) ? cif.bias - span : span - cif.bias;
    rem_sh = {rem_r[15:0], quo_r[31]};
    case (st_r)
      SC_IDLE: begin
        if (cif.start && cif.direct) begin
          res_nxt = cif.fine ? 20'(cif.x) // R15
            : 20'(20'(cif.x) * SPEED_PER_RPM);
          done_nxt = 1'b1;
        end else if (cif.start) begin
          // a word held from the other reading may pass full scale;
          // the clamp keeps the quotient within mag, the bias-to-span distance
          quo_nxt = 32'(mag)
            * 32'((cif.x > cif.full) ? cif.full : cif.x); // R16
          rem_nxt = '0;
          cnt_nxt = '0;
          neg_nxt = cif.bias > span;
          bias_nxt = cif.bias;
          full_nxt = cif.full;
          st_nxt = SC_DIV;
        end
      end
      SC_DIV: begin
        if (rem_sh >= {1'b0, full_r}) begin
          rem_nxt = rem_sh - {1'b0, full_r};
          quo_nxt = {quo_r[30:0], 1'b1};
        end else begin
          rem_nxt = rem_sh;
          quo_nxt = {quo_r[30:0], 1'b0};
        end
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == 5'h1F) begin
          st_nxt = SC_END;
        end
      end
      SC_END: begin
        // quotient never exceeds mag, the bias-to-span distance, so the sum stays in range
        res_nxt = neg_r ? 20'(bias_r) - 20'(quo_r[15:0]) // R16
          : 20'(bias_r) + 20'(quo_r[15:0]);
        done_nxt = 1'b1;
        st_nxt = SC_IDLE;
      end
      default: st_nxt = SC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SC_IDLE;
      cnt_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      neg_r <= 1'b0;
      bias_r <= '0;
      full_r <= '0;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      neg_r <= neg_nxt;
      bias_r <= bias_nxt;
      full_r <= full_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign cif.done = done_r;
  assign cif.result = res_r;

endmodule

`default_nettype wire

// >>> verification/psi_setpoint_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// watches the settings port and the command flags at the top ports
module psi_setpoint_chk import psi_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // requests
  input wire logic DRIVE_RUNNING,
  input wire logic [1:0] PARAMETER_WRITE_PROTECT,
  input wire logic SET_WR,
  input wire logic [2:0] SET_ID,
  input wire logic [15:0] SET_DATA,
  // answers
  input wire logic SET_ACK,
  input wire logic SET_REFUSED,
  input wire logic [19:0] SPEED_CMD,
  input wire logic SPEED_CMD_VALID,
  input wire logic SPEED_CMD_ENABLE,
  input wire logic ANALOG_COMP_ENABLE,
  input wire logic BCD_DIGIT_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////////////////////////////
  // every write gets exactly one answer, and only writes get one
  answer_once_a: assert property (
    SET_WR |=> SET_ACK ^ SET_REFUSED) else $error("write answer wrong");
  no_spurious_a: assert property (
    SET_ACK || SET_REFUSED |-> $past(SET_WR)) else $error("answer unasked");
  // run-time lock, the increment even under open protection
  inc_run_lock_a: assert property (
    SET_WR && SET_ID == 3'h6 && DRIVE_RUNNING |=> SET_REFUSED)
    else $error("increment written in run");
  run_protect_a: assert property (
    SET_WR && DRIVE_RUNNING && PARAMETER_WRITE_PROTECT != WP_RUN_OK
    |=> SET_REFUSED) else $error("protected write taken");
  // range limits of each setting
  strobe_range_a: assert property (
    SET_WR && SET_ID == 3'h5 && SET_DATA > STROBE_MAX |=> SET_REFUSED)
    else $error("strobe use out of range taken");
  type_range_a: assert property (
    SET_WR && SET_ID == 3'h4 && SET_DATA > TYPE_BIN_COMP &&
    SET_DATA != TYPE_OFF |=> SET_REFUSED) else $error("bad type taken");
  bias_range_a: assert property (
    SET_WR && SET_ID inside {3'h0, 3'h2} && SET_DATA > BIAS_MAX
    |=> SET_REFUSED) else $error("bias out of range taken");
  gain_range_a: assert property (
    SET_WR && SET_ID inside {3'h1, 3'h3} && SET_DATA > GAIN_MAX &&
    SET_DATA != GAIN_DIRECT |=> SET_REFUSED) else $error("bad gain taken");
  inc_range_a: assert property (
    SET_WR && SET_ID == 3'h6 && SET_DATA > INC_MAX |=> SET_REFUSED)
    else $error("increment out of range taken");
  // command off gives no speed; compensation only with command on
  off_zero_a: assert property (
    !SPEED_CMD_ENABLE [*2] |-> SPEED_CMD == 20'h00000 && !SPEED_CMD_VALID)
    else $error("speed while disabled");
  comp_on_a: assert property (
    ANALOG_COMP_ENABLE |-> SPEED_CMD_ENABLE) else $error("comp without cmd");

  // main scenarios reached
  cover property (SET_ACK);
  cover property (SET_REFUSED);
  cover property (SPEED_CMD_VALID);
  cover property (BCD_DIGIT_ERROR);
endmodule

bind psi_setpoint psi_setpoint_chk psi_setpoint_chk_inst (.CLK, .RESET_N,
  .DRIVE_RUNNING, .PARAMETER_WRITE_PROTECT, .SET_WR, .SET_ID, .SET_DATA,
  .SET_ACK, .SET_REFUSED, .SPEED_CMD, .SPEED_CMD_VALID, .SPEED_CMD_ENABLE,
  .ANALOG_COMP_ENABLE, .BCD_DIGIT_ERROR);

`default_nettype wire

// >>> verification/psi_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none

// outside controller output stage: contacts hold a level, no clock
module psi_ctl_model (
  // clock
  input wire logic clk,
  // lines toward the block
  output logic [15:0] lines,
  output logic strobe
);
  // contacts open at power-up
  initial begin
    lines = 16'h0000;
    strobe = 1'b0;
  end
  // word and strobe move together just after an edge
  task automatic put(input logic [15:0] w, input logic s);
    @(posedge clk);
    lines <= w;
    strobe <= s;
  endtask
endmodule

`default_nettype wire

// >>> verification/test_psi_setpoint.sv
`timescale 1ns/1ns
`default_nettype none

module test_psi_setpoint import psi_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [1:0] wp = 2'h0;
  logic set_wr = 1'b0;
  logic [2:0] set_id = 3'h0;
  logic [15:0] set_data = 16'h0000;
  wire logic [15:0] lines;
  wire logic stb;
  logic ack, refused, valid, en, comp, derr;
  logic [15:0] rdata, w;
  logic [19:0] speed, e;
  logic [15:0] cfg [8];
  int fails = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////
  psi_setpoint psi_setpoint_inst (.CLK(clk), .RESET_N(rst_n),
    .SETPOINT_LINES(lines), .DATA_READ_STROBE(stb), .DRIVE_RUNNING(run),
    .PARAMETER_WRITE_PROTECT(wp), .SET_WR(set_wr), .SET_ID(set_id),
    .SET_DATA(set_data), .SET_ACK(ack), .SET_REFUSED(refused),
    .SET_RDATA(rdata), .SPEED_CMD(speed), .SPEED_CMD_VALID(valid),
    .SPEED_CMD_ENABLE(en), .ANALOG_COMP_ENABLE(comp),
    .BCD_DIGIT_ERROR(derr));
  psi_ctl_model psi_ctl_model_inst (.clk(clk), .lines(lines), .strobe(stb));

  // 100 MHz
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [19:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // settings as they stand after reset
  task automatic cfg_reset();
    cfg = '{16'h0000, 16'h05DC, 16'h0000, 16'h05DC, 16'h270F, 16'h0000,
      16'h0001, 16'h0000};
  endtask

  // one write, its answer, then read-back against the shadow copy
  task automatic wr(input logic [2:0] id, input logic [15:0] d, input ok);
    @(posedge clk);
    set_wr <= 1'b1;
    set_id <= id;
    set_data <= d;
    @(posedge clk);
    set_wr <= 1'b0;
    #1;
    check("ack", {19'h0, ack}, {19'h0, ok});
    check("refused", {19'h0, refused}, {19'h0, !ok});
    if (ok) cfg[id] = d;
    @(posedge clk);
    #1;
    check("rdata", {4'h0, rdata}, {4'h0, cfg[id]});
  endtask

  // longest pass pair is 70 cycles, 71 from the put, so 80 always covers a fresh result
  task automatic spd(input logic [15:0] x, input logic s, input [19:0] ex);
    psi_ctl_model_inst.put(x, s);
    repeat (80) @(posedge clk);
    #1;
    check("speed", speed, ex);
    check("valid", {19'h0, valid}, 20'h1);
  endtask

  function automatic logic [15:0] dec(input logic [15:0] x);
    return x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0];
  endfunction

  function automatic logic [15:0] rbcd();
    return {4'($urandom_range(9)), 4'($urandom_range(9)),
      4'($urandom_range(9)), 4'($urandom_range(9))};
  endfunction

  // expected speed in 0.1 r/min from a decoded value
  function automatic logic [19:0] want(input logic [15:0] x, input bin);
    longint b, g, f;
    b = bin ? cfg[2] : cfg[0];
    g = bin ? cfg[3] : cfg[1];
    f = bin ? 65535 : 9999;
    if (g == 9999) return (cfg[6] == 0) ? x : x * 10;
    return b + (g * 10 - b) * longint'(x) / f;
  endfunction

  ////////////////////////////////////////////////////////////////
  // run time is about 1900 cycles; this is over fifteen times that
  initial begin
    #300000;
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(10154));
    cfg_reset();
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // all-ones is illegal everywhere: read-back shows reset values
    for (int i = 0; i < 8; i++) wr(i[2:0], 16'hFFFF, 1'b0);
    check("enable", {19'h0, en}, 20'h0);
    wr(3'h0, 16'h8CA0, 1'b1);
    wr(3'h0, 16'h8CA1, 1'b0);
    wr(3'h1, 16'h0E10, 1'b1);
    wr(3'h1, 16'h0E11, 1'b0);
    wr(3'h4, 16'h0004, 1'b0);
    wr(3'h5, 16'h0002, 1'b0);
    wr(3'h6, 16'h0003, 1'b0);
    run <= 1'b1;
    wr(3'h0, 16'h0001, 1'b0);
    wp <= WP_RUN_OK;
    wr(3'h0, 16'h0000, 1'b1);
    wr(3'h6, 16'h0000, 1'b0);
    run <= 1'b0;
    $display("settings test done");
    for (int t = 0; t < 4; t++) begin
      wr(3'h4, t[15:0], 1'b1);
      check("comp", {19'h0, comp}, {19'h0, t > 1});
      check("enable", {19'h0, en}, 20'h1);
    end
    // binary, direct
    wr(3'h3, 16'h270F, 1'b1);
    wr(3'h4, 16'h0001, 1'b1);
    for (int i = 0; i < 5; i++) begin
      w = 16'($urandom());
      spd(w, 1'($urandom()), want(w, 1'b1));
    end
    spd(16'hFFFF, 1'b0, want(16'hFFFF, 1'b1));
    wr(3'h6, 16'h0000, 1'b1);
    spd(16'h0100, 1'b0, 20'h00100);
    // bcd, direct, then a bad digit
    wr(3'h1, 16'h270F, 1'b1);
    wr(3'h4, 16'h0000, 1'b1);
    wr(3'h6, 16'h0002, 1'b1);
    spd(16'h6325, 1'b0, 20'h0F712);
    w = rbcd();
    e = want(dec(w), 1'b0);
    spd(w, 1'b0, e);
    spd(16'h12A4, 1'b0, e);
    check("digit error", {19'h0, derr}, 20'h1);
    spd(16'h9999, 1'b0, want(16'd9999, 1'b0));
    check("digit error", {19'h0, derr}, 20'h0);
    $display("direct test done");
    // interpolated, binary then bcd
    wr(3'h3, 16'h05DC, 1'b1);
    wr(3'h2, 16'h01F4, 1'b1);
    wr(3'h4, 16'h0003, 1'b1);
    spd(16'h0000, 1'b0, 20'h001F4);
    spd(16'hFFFF, 1'b0, 20'h03A98);
    w = 16'($urandom());
    spd(w, 1'b0, want(w, 1'b1));
    // binary gain below bias: the line falls from bias toward the gain; the bcd gain is above bias, so that line rises
    wr(3'h3, 16'h0000, 1'b1);
    spd(16'h8000, 1'b0, want(16'h8000, 1'b1));
    wr(3'h1, 16'h0BB8, 1'b1);
    wr(3'h0, 16'h03E8, 1'b1);
    wr(3'h4, 16'h0002, 1'b1);
    for (int i = 0; i < 3; i++) begin
      w = rbcd();
      spd(w, 1'b0, want(dec(w), 1'b0));
    end
    // command off: speed and valid drop at once
    wr(3'h4, 16'h270F, 1'b1);
    check("enable", {19'h0, en}, 20'h0);
    check("speed off", speed, 20'h00000);
    check("valid off", {19'h0, valid}, 20'h0);
    $display("scaling test done");
    // second reset; lines stay off until strobe use 1 holds the word
    psi_ctl_model_inst.put(16'h0000, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cfg_reset();
    wr(3'h3, 16'h270F, 1'b1);
    wr(3'h5, 16'h0001, 1'b1);
    wr(3'h4, 16'h0001, 1'b1);
    spd(16'h1234, 1'b0, 20'h00000);
    spd(16'h1234, 1'b1, want(16'h1234, 1'b1));
    spd(16'h4321, 1'b0, want(16'h1234, 1'b1));
    spd(16'h4321, 1'b1, want(16'h4321, 1'b1));
    $display("strobe test done");
    close_out();
  end
endmodule

`default_nettype wire
